/* rtl/ssr_device.sv */
// device end: serial shift register, load decode, control register bank
//
// Design decision made here: the APB register port.
`default_nettype none
// Functional notes
// - 24-bit word shifted in msb first
// - low three bits select, upper bits payload
// - load strobe rise copies word to latch
// - codes zero to six map to registers
// - controller never sends select code seven
// - controller writes zero in fixed-zero bits; ssr_ctrl sends pwdata[23:0] as written, without forcing any bit to zero
// - rf up: enable pin high, bit low
// - if up: enable pin high, bit low
// - shared-reference bit zero: independent reference inputs
// - controller sets shared bit for one frequency
// - if reference ratio 3 to 32767
// - register zero field layout
// - mode field selects fractional or integer
// - zero numerator, no compensation gives integer-like
// - integer mode extends counter range
// - dividers feed phase detector via fields
// - power-down mode synchronous or asynchronous
// - counter-reset holds if dividers, pump off
// - pump gain low 100, high 800
// - pump polarity sets if detector sense
module ssr_device #(
  parameter int SYNC_STAGES = 2
) (
  input wire logic core_clk,
  input wire logic srst,
  ssr_if.dev link,
  output logic rf_powered_up,
  output logic if_powered_up,
  output logic shared_reference,
  output logic power_down_sync,
  output logic if_counter_reset,
  output logic if_pump_gain,
  output logic if_pump_polarity,
  output logic [14:0] if_reference_ratio,
  output logic if_ratio_valid,
  output logic integer_mode,
  output logic fraction_compensation_enable,
  output logic [20:0] reg_bank [0:6]
);
  import ssr_pkg::*;
  if (SYNC_STAGES != 2) begin : g_bad_sync
    $error("ssr_device: two synchroniser stages only");
  end
  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers, two stages per pin
  localparam int PINS = 5;
  wire [PINS-1:0] pin_raw = {link.if_enable_pin, link.rf_enable_pin, link.load_strobe,
                             link.sdata, link.sclk};
  logic [PINS-1:0] pin_meta_ff;
  logic [PINS-1:0] pin_sync_ff;
  logic sclk_prev_ff;
  logic le_prev_ff;
  genvar s;
  generate
    for (s = 0; s < PINS; s++) begin : g_sync
      always_ff @(posedge core_clk) begin
        pin_meta_ff[s] <= pin_raw[s];
        pin_sync_ff[s] <= pin_meta_ff[s];
      end
    end
  endgenerate
  wire sclk_s = pin_sync_ff[0];
  wire data_s = pin_sync_ff[1];
  wire le_s = pin_sync_ff[2];
  wire rfen_s = pin_sync_ff[3];
  wire ifen_s = pin_sync_ff[4];
  // edge detectors read only the second stage
  always_ff @(posedge core_clk) begin
    sclk_prev_ff <= sclk_s;
    le_prev_ff <= le_s;
  end
  wire sclk_rise = sclk_s & ~sclk_prev_ff;
  wire le_rise = le_s & ~le_prev_ff;
  ////////////////////////////////////////////////////////////////////////
  // shift register, never gated by power-down
  logic [23:0] shift_ff;
  wire [23:0] nxt_shift = sclk_rise ? {shift_ff[22:0], data_s} : shift_ff;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      shift_ff <= 24'h000000;
    end else begin
      shift_ff <= nxt_shift;
    end
  end
  wire [2:0] register_select_code = shift_ff[2:0];
  wire [20:0] payload = shift_ff[23:3];
  ////////////////////////////////////////////////////////////////////////
  // latch bank
  logic [20:0] bank_ff [0:6];
  genvar g;
  generate
    for (g = 0; g < NUM_REGS; g++) begin : g_bank
      wire hit = le_rise && (register_select_code == 3'(g));
      always_ff @(posedge core_clk) begin
        if (srst) begin
          bank_ff[g] <= PAY_RESET;
        end else if (hit) begin
          bank_ff[g] <= payload;
        end
      end
      always_ff @(posedge core_clk) begin
        reg_bank[g] <= srst ? PAY_RESET : bank_ff[g];
      end
    end
  endgenerate
  ////////////////////////////////////////////////////////////////////////
  // field decode
  wire [23:0] w_ifr = {bank_ff[REG_IF_REF], 3'h0};
  wire [23:0] w_iffb = {bank_ff[REG_IF_FB], 3'h0};
  wire [23:0] w_rffb = {bank_ff[REG_RF_FB], 3'h0};
  wire [23:0] w_rfl = {bank_ff[REG_RF_LOCK], 3'h0};
  wire [23:0] w_glb = {bank_ff[REG_GLOBAL], 3'h0};
  wire nxt_rf_up = rfen_s & ~w_rffb[POS_PD];
  wire nxt_if_up = ifen_s & ~w_iffb[POS_PD];
  wire nxt_shared_ref = w_glb[POS_SHARED_REF];
  wire nxt_pd_sync = w_glb[POS_PD_MODE];
  wire nxt_if_rst = w_ifr[POS_IF_RST];
  wire nxt_if_gain = w_ifr[POS_IF_GAIN];
  wire nxt_if_pol = w_ifr[POS_IF_POL];
  wire [14:0] nxt_ifr = w_ifr[POS_IF_R_HI:POS_IF_R_LO];
  wire nxt_ifr_ok = (nxt_ifr >= IF_R_MIN);
  wire [1:0] om = w_rfl[POS_OM_HI:POS_OM_LO];
  wire nxt_int_mode = (om == 2'h0);
  wire nxt_fce = w_glb[POS_FE];
  ////////////////////////////////////////////////////////////////////////
  // loop power gating
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rf_powered_up <= 1'b0;
    end else begin
      rf_powered_up <= nxt_rf_up;
    end
  end
  always_ff @(posedge core_clk) begin
    if (srst) begin
      if_powered_up <= 1'b0;
    end else begin
      if_powered_up <= nxt_if_up;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // reference sharing and power-down mode
  always_ff @(posedge core_clk) begin
    if (srst) begin
      shared_reference <= 1'b0;
    end else begin
      shared_reference <= nxt_shared_ref;
    end
  end
  always_ff @(posedge core_clk) begin
    if (srst) begin
      power_down_sync <= 1'b0;
    end else begin
      power_down_sync <= nxt_pd_sync;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // if reference divider controls
  always_ff @(posedge core_clk) begin
    if (srst) begin
      if_counter_reset <= 1'b0;
    end else begin
      if_counter_reset <= nxt_if_rst;
    end
  end
  always_ff @(posedge core_clk) begin
    if (srst) begin
      if_pump_gain <= 1'b0;
    end else begin
      if_pump_gain <= nxt_if_gain;
    end
  end
  always_ff @(posedge core_clk) begin
    if (srst) begin
      if_pump_polarity <= 1'b0;
    end else begin
      if_pump_polarity <= nxt_if_pol;
    end
  end
  always_ff @(posedge core_clk) begin
    if (srst) begin
      if_reference_ratio <= 15'h0000;
    end else begin
      if_reference_ratio <= nxt_ifr;
    end
  end
  always_ff @(posedge core_clk) begin
    if (srst) begin
      if_ratio_valid <= 1'b0;
    end else begin
      if_ratio_valid <= nxt_ifr_ok;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // rf operating mode
  always_ff @(posedge core_clk) begin
    if (srst) begin
      integer_mode <= 1'b0;
    end else begin
      integer_mode <= nxt_int_mode;
    end
  end
  always_ff @(posedge core_clk) begin
    if (srst) begin
      fraction_compensation_enable <= 1'b0;
    end else begin
      fraction_compensation_enable <= nxt_fce;
    end
  end
endmodule
`default_nettype wire

/* rtl/ssr_pkg.sv */
// package: register map, field positions and timing constants of the serial load port
`default_nettype none
package ssr_pkg;
  localparam int WORD_W = 24;
  localparam int SEL_W = 3;
  localparam int PAY_W = 21;
  localparam int NUM_REGS = 7;
  localparam logic [2:0] SEL_INVALID = 3'h7;
  localparam logic [2:0] REG_IF_REF = 3'h0;
  localparam logic [2:0] REG_IF_FB = 3'h1;
  localparam logic [2:0] REG_IF_TOC = 3'h2;
  localparam logic [2:0] REG_RF_REF = 3'h3;
  localparam logic [2:0] REG_RF_FB = 3'h4;
  localparam logic [2:0] REG_RF_LOCK = 3'h5;
  localparam logic [2:0] REG_GLOBAL = 3'h6;
  // word bit positions
  localparam int POS_PD = 23;
  localparam int POS_IF_RST = 20;
  localparam int POS_IF_GAIN = 19;
  localparam int POS_IF_POL = 18;
  localparam int POS_IF_R_HI = 17;
  localparam int POS_IF_R_LO = 3;
  localparam int POS_FE = 16;
  localparam int POS_PD_MODE = 8;
  localparam int POS_SHARED_REF = 7;
  localparam int POS_OM_HI = 20;
  localparam int POS_OM_LO = 19;
  localparam logic [20:0] PAY_RESET = 21'h000000;
  localparam logic [14:0] IF_R_MIN = 15'h0003;
  // controller timing and apb register addresses
  localparam int SCLK_DIV = 2;
  localparam int APB_REG_CTRL = 32'h0000_0000;
  localparam int APB_REG_WORD = 32'h0000_0004;
  localparam int APB_REG_STAT = 32'h0000_0008;
endpackage
`default_nettype wire

/* rtl/ssr_if.sv */
// interface: three-wire serial programming link and enable pins
`default_nettype none
interface ssr_if;
  logic sclk;
  logic sdata;
  logic load_strobe;
  logic rf_enable_pin;
  logic if_enable_pin;
  modport ctrl (output sclk, output sdata, output load_strobe,
                output rf_enable_pin, output if_enable_pin);
  modport dev (input sclk, input sdata, input load_strobe,
               input rf_enable_pin, input if_enable_pin);
endinterface
`default_nettype wire

/* rtl/ssr_ctrl.sv */
// controller end: apb slave that serialises 24-bit words onto the link
`default_nettype none
module ssr_ctrl (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  ssr_if.ctrl link
);
  import ssr_pkg::*;
  typedef enum logic [1:0] {SSR_IDLE = 2'h0, SSR_LOW = 2'h1, SSR_HIGH = 2'h3,
                            SSR_LOAD = 2'h2} ssr_state_t;
  ////////////////////////////////////////////////////////////////////////
  // apb decode
  ssr_state_t state_ff;
  logic [23:0] word_ff;
  logic [4:0] bit_ff;
  logic [1:0] en_ff;
  logic rejected_ff;
  wire acc = psel & penable & ~pready;
  wire wr_word = acc & pwrite & (paddr == 32'(APB_REG_WORD));
  wire wr_ctrl = acc & pwrite & (paddr == 32'(APB_REG_CTRL));
  wire busy = (state_ff != SSR_IDLE);
  wire bad_sel = (pwdata[2:0] == SEL_INVALID);
  wire start = wr_word & ~busy & ~bad_sel;
  wire mapped = (paddr == 32'(APB_REG_CTRL)) | (paddr == 32'(APB_REG_WORD)) |
                (paddr == 32'(APB_REG_STAT));
  wire [31:0] rd_val = (paddr == 32'(APB_REG_CTRL)) ? {30'h0, en_ff} :
                       (paddr == 32'(APB_REG_STAT)) ? {30'h0, rejected_ff, busy} : 32'h0;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      en_ff <= 2'h0;
      rejected_ff <= 1'b0;
    end else begin
      pready <= acc;
      pslverr <= acc & (~mapped | (wr_word & (busy | bad_sel)));
      prdata <= (acc & ~pwrite) ? rd_val : 32'h0;
      if (wr_ctrl) begin
        en_ff <= pwdata[1:0];
      end
      if (wr_word) begin
        rejected_ff <= busy | bad_sel;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // serialiser: data changes on falling serial clock, msb first
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_ff <= SSR_IDLE;
      word_ff <= 24'h000000;
      bit_ff <= 5'h00;
      link.sclk <= 1'b0;
      link.sdata <= 1'b0;
      link.load_strobe <= 1'b0;
      link.rf_enable_pin <= 1'b0;
      link.if_enable_pin <= 1'b0;
    end else begin
      link.rf_enable_pin <= en_ff[0];
      link.if_enable_pin <= en_ff[1];
      case (state_ff)
        SSR_IDLE: begin
          link.load_strobe <= 1'b0;
          if (start) begin
            word_ff <= pwdata[23:0];
            bit_ff <= 5'h17;
            link.sdata <= pwdata[23];
            state_ff <= SSR_LOW;
          end
        end
        SSR_LOW: begin
          link.sclk <= 1'b1;
          state_ff <= SSR_HIGH;
        end
        SSR_HIGH: begin
          link.sclk <= 1'b0;
          if (bit_ff == 5'h00) begin
            state_ff <= SSR_LOAD;
          end else begin
            bit_ff <= bit_ff - 5'h01;
            link.sdata <= word_ff[bit_ff - 5'h01];
            state_ff <= SSR_LOW;
          end
        end
        SSR_LOAD: begin
          link.load_strobe <= 1'b1;
          state_ff <= SSR_IDLE;
        end
        default: begin
          state_ff <= SSR_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

/* bench/ssr_chk.sv */
// checker: link framing between controller and device
`default_nettype none
module ssr_chk (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic sclk,
  input wire logic sdata,
  input wire logic load_strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sclk_ff;
  logic [4:0] bits_ff;
  logic [23:0] word_ff;
  wire clk_rise = sclk & ~sclk_ff;
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  always_ff @(posedge core_clk) begin
    sclk_ff <= srst ? 1'b0 : sclk;
    if (srst || load_strobe) bits_ff <= 5'h00;
    else if (clk_rise) bits_ff <= bits_ff + 5'h01;
    if (clk_rise) word_ff <= {word_ff[22:0], sdata};
  end
  ////////////////////////////////////////////////////////////////
  sequence s_pulse;
    sclk ##1 !sclk;
  endsequence
  sequence s_frame_end;
    ##[0:4] load_strobe;
  endsequence
  a_sclk_pulse: assert property ($rose(sclk) |-> s_pulse)
    else $error("serial clock high too long");
  a_data_held: assert property (sclk |-> $stable(sdata))
    else $error("data moved while clock high");
  a_strobe_pulse: assert property ($rose(load_strobe) |=> !load_strobe)
    else $error("strobe longer than one cycle");
  a_strobe_no_clk: assert property (load_strobe |-> !sclk)
    else $error("strobe during clock");
  a_word_length: assert property ($rose(load_strobe) |-> bits_ff == 5'h18)
    else $error("strobe after wrong bit count");
  a_no_extra_bit: assert property (clk_rise |-> bits_ff < 5'h18)
    else $error("more than 24 bits in a word");
  a_strobe_soon: assert property (bits_ff == 5'h18 |-> s_frame_end)
    else $error("no strobe after full word");
  a_sel_valid: assert property ($rose(load_strobe) |-> word_ff[2:0] != 3'h7)
    else $error("invalid select sent");
endmodule
`default_nettype wire

/* bench/synth_serial_register_load_tb.sv */
// testbench: apb controller and serial device joined over the link
`default_nettype none
module synth_serial_register_load_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ssr_pkg::*;
  logic core_clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, rfu, ifu, shr, pds, icr, ipg, ipp, irv, intm, fce;
  logic [14:0] irr;
  logic [20:0] bank [0:6];
  int bad_count = 0, n_tests = 0, cyc = 0;
  ssr_if ssr_if_inst ();
  ssr_ctrl ssr_ctrl_inst (.core_clk(core_clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(ssr_if_inst.ctrl));
  ssr_device ssr_device_inst (.core_clk(core_clk), .srst(srst), .link(ssr_if_inst.dev),
    .rf_powered_up(rfu), .if_powered_up(ifu), .shared_reference(shr), .power_down_sync(pds),
    .if_counter_reset(icr), .if_pump_gain(ipg), .if_pump_polarity(ipp),
    .if_reference_ratio(irr), .if_ratio_valid(irv), .integer_mode(intm),
    .fraction_compensation_enable(fce), .reg_bank(bank));
  ssr_chk ssr_chk_inst (.core_clk(core_clk), .srst(srst), .sclk(ssr_if_inst.sclk),
    .sdata(ssr_if_inst.sdata), .load_strobe(ssr_if_inst.load_strobe));
  initial begin
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      print_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////
  task print_verdict;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task chk(input bit c, input string m);
    n_tests++;
    if (!c) begin
      bad_count++;
      $display("mismatch %0t %s", $time, m);
    end
  endtask
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task wait_idle;
    do apb(1'b0, APB_REG_STAT, 32'h0); while (rd[0] !== 1'b0);
    repeat (8) @(posedge core_clk);
  endtask
  task send(input logic [23:0] wd);
    apb(1'b1, APB_REG_WORD, {8'h00, wd});
    wait_idle();
  endtask
  ////////////////////////////////////////////////////////////////
  task t_map;
    for (int i = 0; i < 7; i++) send({21'h002010 + 21'(i), 3'(i)});
    for (int i = 0; i < 7; i++) chk(bank[i] === 21'h002010 + 21'(i), "bank");
  endtask
  task t_fields;
    send({3'h0, 3'b101, 15'h0003, REG_IF_REF});
    chk({icr, ipg, ipp, irr, irv} === {3'b101, 15'h0003, 1'b1}, "r0 fields");
    send({3'h0, 3'b010, 15'h0002, REG_IF_REF});
    chk({icr, ipg, ipp, irr, irv} === {3'b010, 15'h0002, 1'b0}, "ratio 2");
    send({7'h00, 1'b1, 7'h00, 1'b1, 1'b1, 4'h0, REG_GLOBAL});
    chk({fce, pds, shr} === 3'b111, "global set");
    send(24'h000006);
    chk({fce, pds, shr} === 3'b000, "global clear");
    send(24'h000004);
    chk(fce === 1'b0 && bank[4][6:0] === 7'h00, "integer-like setup");
    send(24'h000005);
    chk(intm === 1'b1, "integer mode");
    send(24'h080005);
    chk(intm === 1'b0, "fractional mode");
    send(24'h180005);
    chk(intm === 1'b0, "mode three");
  endtask
  task t_power;
    for (int k = 0; k < 8; k++) begin
      apb(1'b1, APB_REG_CTRL, 32'(k & 3));
      send({k[2], 20'h00100, REG_IF_FB});
      send({k[2], 20'h00200, REG_RF_FB});
      chk(rfu === (k[0] & ~k[2]), "rf power");
      chk(ifu === (k[1] & ~k[2]), "if power");
      chk(bank[4] === {k[2], 20'h00200}, "load while down");
    end
    apb(1'b0, APB_REG_CTRL, 32'h0);
    chk(rd[1:0] === 2'b11, "ctrl readback");
  endtask
  task t_refuse;
    apb(1'b1, APB_REG_WORD, 32'h00FFFFFF);
    chk(er === 1'b1, "select 7 taken");
    apb(1'b0, APB_REG_STAT, 32'h0);
    chk(rd[1] === 1'b1, "reject flag");
    apb(1'b1, 32'h0000000C, 32'h0);
    chk(er === 1'b1, "unmapped taken");
    apb(1'b1, APB_REG_WORD, 32'h00000086);
    chk(er === 1'b0, "good word refused");
    apb(1'b1, APB_REG_WORD, 32'h00FFFF86);
    chk(er === 1'b1, "busy write taken");
    wait_idle();
    chk(bank[6] === 21'h000010 && shr === 1'b1, "busy word leaked");
  endtask
  initial begin
    repeat (12) @(posedge core_clk);
    srst <= 1'b0;
    t_map();
    t_fields();
    t_power();
    t_refuse();
    print_verdict();
  end
endmodule
`default_nettype wire
